// *** sim/wdtr_tb.sv ***
`timescale 1ns/1ps
module tb;
    import wdtr_pkg::*;
    logic         i_sys_clk           = 1'b0;
    logic         i_rstn              = 1'b0;
    wdtr_io_req_t i_io                = '0;
    logic [7:0]   o_io_rdata;
    logic         i_osc_tick          = 1'b0;
    logic         i_wdr               = 1'b0;
    logic         i_safety_level_fuse = 1'b0;
    logic         i_global_ie         = 1'b1;
    logic         i_irq_ack           = 1'b0;
    logic         i_ext_rst           = 1'b0;
    logic         i_bor_rst           = 1'b0;
    logic         o_irq;
    logic         o_wdt_reset;
    int           err_count           = 0;
    int           samples_checked     = 0;
    int           cyc                 = 0;

    wdtr_top dut (.i_sys_clk, .i_rstn, .i_io, .o_io_rdata, .i_osc_tick,
        .i_wdr, .i_safety_level_fuse, .i_global_ie, .i_irq_ack,
        .i_ext_rst, .i_bor_rst, .o_irq, .o_wdt_reset);

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic end_sim();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // The longest run is four time-outs of 2048 ticks plus register traffic.
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            $display("mismatch at %0t: run did not finish", $time);
            end_sim();
        end
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            err_count++;
            $display("mismatch at %0t: %0d cycles not %0d", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        i_rstn = 1'b0;
        repeat (16) @(negedge i_sys_clk);
        i_rstn = 1'b1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        i_io = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_sys_clk);
        i_io = '0;
    endtask

    // Read data is registered, so it is looked at one cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_sys_clk);
        i_io = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge i_sys_clk);
        i_io = '0;
        chk_byte(o_io_rdata, exp);
    endtask

    task automatic pulse(input int k);
        @(negedge i_sys_clk);
        {i_irq_ack, i_bor_rst, i_ext_rst} = 3'b001 << k;
        @(negedge i_sys_clk);
        {i_irq_ack, i_bor_rst, i_ext_rst} = 3'b000;
    endtask

    // Restart, then tick every cycle at prescale code 0 until a time-out.
    task automatic run(input logic rst);
        int n;
        @(negedge i_sys_clk);
        i_wdr = 1'b1;
        @(negedge i_sys_clk);
        i_wdr = 1'b0;
        i_osc_tick = 1'b1;
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (o_irq !== 1'b1 && o_wdt_reset !== 1'b1 && n < 3000);
        i_osc_tick = 1'b0;
        chk_cnt(n, 2048);
        chk_byte({6'h00, o_wdt_reset, o_irq}, {6'h00, rst, !rst});
        if (rst) begin
            @(negedge i_sys_clk);
            chk_byte({7'h00, o_wdt_reset}, 8'h00);
        end
    endtask

    initial begin
        do_reset();
        rd(WCS_ADDR, 8'h00);
        rd(RCS_ADDR, 8'h01);
        rd(8'h50, 8'h00);
        wr(WCS_ADDR, 8'h08);
        rd(WCS_ADDR, 8'h08);
        wr(WCS_ADDR, 8'h00);
        wr(WCS_ADDR, 8'h2b);
        rd(WCS_ADDR, 8'h08);
        wr(WCS_ADDR, 8'h18);
        rd(WCS_ADDR, 8'h18);
        wr(WCS_ADDR, 8'h21);
        rd(WCS_ADDR, 8'h21);
        wr(WCS_ADDR, 8'h39);
        repeat (4) @(posedge i_sys_clk);
        rd(WCS_ADDR, 8'h29);
        wr(WCS_ADDR, 8'h21);
        rd(WCS_ADDR, 8'h29);
        wr(WCS_ADDR, 8'h18);
        wr(WCS_ADDR, 8'h08);
        rd(WCS_ADDR, 8'h08);
        run(1'b1);
        rd(RCS_ADDR, 8'h09);
        rd(WCS_ADDR, 8'h08);
        wr(WCS_ADDR, 8'h18);
        wr(WCS_ADDR, 8'h00);
        rd(WCS_ADDR, 8'h08);
        wr(RCS_ADDR, 8'h00);
        rd(RCS_ADDR, 8'h00);
        wr(WCS_ADDR, 8'h18);
        wr(WCS_ADDR, 8'h00);
        rd(WCS_ADDR, 8'h00);
        pulse(0);
        rd(RCS_ADDR, 8'h02);
        pulse(1);
        rd(RCS_ADDR, 8'h06);
        wr(RCS_ADDR, 8'hfd);
        rd(RCS_ADDR, 8'h04);
        wr(WCS_ADDR, 8'h40);
        run(1'b0);
        rd(WCS_ADDR, 8'hc0);
        @(negedge i_sys_clk);
        i_global_ie = 1'b0;
        #1 chk_byte({7'h00, o_irq}, 8'h00);
        @(negedge i_sys_clk);
        i_global_ie = 1'b1;
        pulse(2);
        chk_byte({7'h00, o_irq}, 8'h00);
        rd(WCS_ADDR, 8'h40);
        wr(WCS_ADDR, 8'h48);
        run(1'b0);
        rd(WCS_ADDR, 8'h88);
        wr(WCS_ADDR, 8'h88);
        rd(WCS_ADDR, 8'h08);
        run(1'b1);
        i_safety_level_fuse = 1'b1;
        do_reset();
        rd(WCS_ADDR, 8'h08);
        rd(RCS_ADDR, 8'h01);
        wr(WCS_ADDR, 8'h18);
        wr(WCS_ADDR, 8'h01);
        rd(WCS_ADDR, 8'h09);
        wr(WCS_ADDR, 8'h02);
        rd(WCS_ADDR, 8'h09);
        wr(WCS_ADDR, 8'h00);
        rd(WCS_ADDR, 8'h09);
        end_sim();
    end
endmodule

// *** verilog/wdtr_pkg.sv ***
package wdtr_pkg;
    localparam logic [7:0] WCS_ADDR  = 8'h21;
    localparam logic [7:0] RCS_ADDR  = 8'h34;
    localparam int         IF_BIT    = 7;
    localparam int         IE_BIT    = 6;
    localparam int         PS_HI_BIT = 5;
    localparam int         CE_BIT    = 4;
    localparam int         EN_BIT    = 3;
    localparam int         WD_BIT    = 3;
    localparam int         BO_BIT    = 2;
    localparam int         EX_BIT    = 1;
    localparam int         PO_BIT    = 0;
    localparam logic [3:0] RCS_RST   = 4'h1;
    localparam logic [3:0] PS_RST    = 4'h0;
    localparam logic [3:0] PS_MAX    = 4'h9;
    localparam logic [2:0] WIN_CYC   = 3'h4;
    localparam int         CNT_W     = 20;
    localparam int         BASE_LOG2 = 11;

    typedef enum logic {
        WIN_IDLE = 1'b0,
        WIN_OPEN = 1'b1
    } wdtr_win_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdtr_io_req_t;
endpackage

// *** verilog/wdtr_top.sv ***
`timescale 1ns/1ps
// Contract
// - Level 1 starts disabled; writing one to enable enables freely.
// - Level 2 keeps the watchdog running; enable reads as one.
// - Level 2 prescale change uses the same two-write timed sequence.
// - Level 2 ignores every disable attempt.
// - Change-enable clears itself four clocks after being set.
// - Enable clears only with the change window open.
// - Prescale writes outside the change window are ignored.
// - Level 1 forces enable on while the watchdog cause flag is set.
// - Watchdog cause flag set on watchdog reset, cleared by zero write.
// - Brown-out cause flag set on brown-out, cleared by zero write.
// - Pin cause flag set on pin reset, cleared by zero write.
// - Power-on flag set at power-on, cleared only by zero write.
// - Upper four cause bits read as zero.
// - Interrupt flag set on interrupt time-out; cleared by vector or one.
// - Interrupt requested only with global enable and flag, plus irq enable or armed by a both-on time-out.
// - Both off stops; irq enable alone interrupts; enable alone resets.
// - Both on: interrupt, clear irq enable; next time-out resets.
// - Prescale code selects 2K doubling up to 1024K oscillator cycles.
// - Prescale top bit at position 5, low bits at 2 to 0.
// - Reserved prescale codes fall back to a valid lower setting.
// - Counter advances on ticks of the separate 128 kHz oscillator.
// - Restart, disable or chip reset clears the counter.
// - Fuse selects level: unprogrammed level 1, programmed level 2.
// - Reset time-out gives a one-cycle reset pulse.
module wdtr_top
    import wdtr_pkg::*;
(
    input  wire logic         i_sys_clk,      // System clock, 100 MHz.
    input  wire logic         i_rstn,         // Power-on reset, active low.
    input  wire wdtr_io_req_t i_io,           // Register port request.
    output logic [7:0]        o_io_rdata,     // Registered read data.
    input  wire logic         i_osc_tick,     // One pulse per osc cycle.
    input  wire logic         i_wdr,          // Restart instruction pulse.
    input  wire logic         i_safety_level_fuse, // High: programmed.
    input  wire logic         i_global_ie,    // Global interrupt enable.
    input  wire logic         i_irq_ack,      // Vector executed pulse.
    input  wire logic         i_ext_rst,      // Pin reset event pulse.
    input  wire logic         i_bor_rst,      // Brown-out reset event pulse.
    output logic              o_irq,          // Time-out interrupt request.
    output logic              o_wdt_reset     // One-cycle reset pulse.
);
    function automatic logic [CNT_W-1:0] limit_of(input logic [3:0] code);
        logic [3:0] c;
        c = (code > PS_MAX) ? PS_MAX : code;
        return CNT_W'((32'h1 << (BASE_LOG2 + int'(c))) - 1);
    endfunction

    wdtr_win_t        win_q;
    logic [2:0]       win_cnt_q;
    logic             en_q;
    logic             ie_q;
    logic             if_q;
    logic             armed_q;
    logic [3:0]       ps_q;
    logic [3:0]       rc_q;
    logic [CNT_W-1:0] cnt_q;
    logic             rst_pulse_q;
    logic             level2;
    logic             wr_wcs;
    logic             wr_rcs;
    logic             open_req;
    logic             win_write;
    logic             chip_rst;
    logic             en_eff;
    logic             running;
    logic             timeout;
    logic             to_irq;
    logic             to_rst;
    logic [7:0]       wd;
    logic [7:0]       wcs_rd;

    assign level2    = i_safety_level_fuse;
    assign wd        = i_io.wdata;
    assign wr_wcs    = i_io.wr && (i_io.addr == WCS_ADDR);
    assign wr_rcs    = i_io.wr && (i_io.addr == RCS_ADDR);
    assign open_req  = wr_wcs && wd[CE_BIT] && wd[EN_BIT];
    assign win_write = wr_wcs && (win_q == WIN_OPEN) && !wd[CE_BIT];
    // Any non power-on reset reinitialises control but keeps cause flags.
    assign chip_rst  = rst_pulse_q || i_ext_rst || i_bor_rst;
    assign en_eff    = level2 || en_q;
    assign running   = en_eff || ie_q;
    assign timeout   = running && i_osc_tick && (cnt_q == limit_of(ps_q));
    assign to_irq    = timeout && ie_q;
    assign to_rst    = timeout && !ie_q && en_eff;

    // Change window: open for four cycles after the opening write, or until a write in it with the change bit clear.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            win_q     <= WIN_IDLE;
            win_cnt_q <= 3'h0;
        end else if (chip_rst) begin
            win_q     <= WIN_IDLE;
            win_cnt_q <= 3'h0;
        end else if (open_req) begin
            win_q     <= WIN_OPEN;
            win_cnt_q <= WIN_CYC;
        end else begin
            unique case (win_q)
                WIN_IDLE: begin
                    win_cnt_q <= 3'h0;
                end
                WIN_OPEN: begin
                    win_cnt_q <= win_cnt_q - 3'h1;
                    if (win_write || win_cnt_q == 3'h1) begin
                        win_q <= WIN_IDLE;
                    end
                end
            endcase
        end
    end

    // Enable: set freely, cleared only inside the window at level 1.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            en_q <= 1'b0;
        end else if (chip_rst) begin
            en_q <= 1'b0;
        end else if (rc_q[WD_BIT]) begin
            en_q <= 1'b1;
        end else if (win_write && !level2) begin
            en_q <= wd[EN_BIT];
        end else if (wr_wcs && wd[EN_BIT]) begin
            en_q <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ps_q <= PS_RST;
        end else if (chip_rst) begin
            ps_q <= PS_RST;
        end else if (win_write) begin
            ps_q <= {wd[PS_HI_BIT], wd[2:0]};
        end
    end

    // A software write of the irq enable wins over the hardware clear so
    // that a handler re-arming at the time-out edge is not lost.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ie_q <= 1'b0;
        end else if (chip_rst) begin
            ie_q <= 1'b0;
        end else if (wr_wcs) begin
            ie_q <= wd[IE_BIT];
        end else if (to_irq && en_eff) begin
            ie_q <= 1'b0;
        end
    end

    // Keeps the pending request alive after the enable was cleared.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            armed_q <= 1'b0;
        end else if (to_irq && en_eff) begin
            armed_q <= 1'b1;
        end else if (chip_rst || !if_q) begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            if_q <= 1'b0;
        end else if (to_irq) begin
            if_q <= 1'b1;
        end else if (chip_rst || i_irq_ack || (wr_wcs && wd[IF_BIT])) begin
            if_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
        end else if (chip_rst || !running || i_wdr || timeout) begin
            cnt_q <= '0;
        end else if (i_osc_tick) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_pulse_q <= 1'b0;
        end else begin
            rst_pulse_q <= to_rst && !chip_rst;
        end
    end

    // Hardware sets win over a software zero write in the same cycle.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rc_q <= RCS_RST;
        end else begin
            rc_q <= (wr_rcs ? (rc_q & wd[3:0]) : rc_q)
                  | {rst_pulse_q, i_bor_rst, i_ext_rst, 1'b0};
        end
    end

    assign wcs_rd = {if_q, ie_q, ps_q[3], win_q == WIN_OPEN, en_eff,
                     ps_q[2:0]};

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_io_rdata <= 8'h00;
        end else if (i_io.rd && i_io.addr == WCS_ADDR) begin
            o_io_rdata <= wcs_rd;
        end else if (i_io.rd && i_io.addr == RCS_ADDR) begin
            o_io_rdata <= {4'h0, rc_q};
        end else begin
            o_io_rdata <= 8'h00;
        end
    end

    assign o_irq = if_q && i_global_ie && (ie_q || armed_q);
    assign o_wdt_reset = rst_pulse_q;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_open;
        open_req && !chip_rst;
    endsequence
    sequence s_quiet4;
        (!wr_wcs && !chip_rst) [*4];
    endsequence

    // The window closes on the edge after its fourth open cycle, so the
    // closed state is looked at one cycle after the quiet stretch.
    a_win_opens: assert property (s_open |=> win_q == WIN_OPEN)
        else $error("change window did not open");

    a_win_closes: assert property (
        s_open ##1 s_quiet4 |=> win_q == WIN_IDLE)
        else $error("change window not closed after four cycles");

    a_en_holds: assert property (
        wr_wcs && !wd[EN_BIT] && win_q == WIN_IDLE && en_q && !chip_rst
        |=> en_q)
        else $error("enable cleared outside window");

    a_l2_enable: assert property (level2 |-> wcs_rd[EN_BIT])
        else $error("level 2 enable not reading one");

    a_ps_ignore: assert property (
        wr_wcs && win_q == WIN_IDLE && !chip_rst |=> ps_q == $past(ps_q))
        else $error("prescale changed outside window");

    // The cause flag is set from the registered pulse, one edge later.
    a_rst_pulse: assert property (
        to_rst && !chip_rst
        |=> o_wdt_reset ##1 !o_wdt_reset ##1 rc_q[WD_BIT])
        else $error("reset pulse not one cycle or cause flag unset");

    a_irq_gate: assert property (o_irq |-> if_q && i_global_ie)
        else $error("interrupt without flag or global enable");

    a_ie_hwclr: assert property (
        to_irq && en_eff && !wr_wcs && !chip_rst
        |=> if_q && !ie_q && o_irq == i_global_ie)
        else $error("irq enable not cleared or request lost");

    a_watchdog_cause_flag_force: assert property (
        rc_q[WD_BIT] && !chip_rst |=> en_q)
        else $error("enable not forced by cause flag");

    a_en_set: assert property (
        wr_wcs && wd[EN_BIT] && !chip_rst |=> en_eff)
        else $error("enable write did not enable");

    a_l2_disable: assert property (
        level2 && wr_wcs && !wd[EN_BIT] |=> wcs_rd[EN_BIT])
        else $error("level 2 watchdog was disabled");

    a_win_shut: assert property (
        win_write |=> win_q == WIN_IDLE)
        else $error("window still open after its write");

    a_win_reads: assert property (
        win_q == WIN_OPEN |-> wcs_rd[CE_BIT])
        else $error("open window not shown in change bit");

    a_en_clear: assert property (
        win_write && !level2 && !rc_q[WD_BIT] && !chip_rst
        |=> en_q == $past(wd[EN_BIT]))
        else $error("window write did not set enable");

    a_ps_load: assert property (
        win_write && !chip_rst
        |=> ps_q == {$past(wd[PS_HI_BIT]), $past(wd[2:0])})
        else $error("prescale not loaded in window");

    a_wd_flag: assert property (
        o_wdt_reset |=> rc_q[WD_BIT])
        else $error("watchdog cause flag not set");

    a_bo_flag: assert property (
        i_bor_rst |=> rc_q[BO_BIT])
        else $error("brown-out cause flag not set");

    a_ex_flag: assert property (
        i_ext_rst |=> rc_q[EX_BIT])
        else $error("pin cause flag not set");

    a_wd_clear: assert property (
        wr_rcs && !wd[WD_BIT] && !o_wdt_reset |=> !rc_q[WD_BIT])
        else $error("watchdog cause flag not cleared");

    a_bo_clear: assert property (
        wr_rcs && !wd[BO_BIT] && !i_bor_rst |=> !rc_q[BO_BIT])
        else $error("brown-out cause flag not cleared");

    a_po_hold: assert property (
        !(wr_rcs && !wd[PO_BIT]) |=> rc_q[PO_BIT] == $past(rc_q[PO_BIT]))
        else $error("power-on flag changed without a zero write");

    a_po_clear: assert property (
        wr_rcs && !wd[PO_BIT] |=> !rc_q[PO_BIT])
        else $error("power-on flag not cleared");

    a_rc_upper: assert property (
        i_io.rd && i_io.addr == RCS_ADDR |=> o_io_rdata[7:4] == 4'h0)
        else $error("reserved cause bits not zero");

    a_if_set: assert property (
        to_irq |=> if_q)
        else $error("interrupt flag not set on time-out");

    a_if_ack: assert property (
        i_irq_ack && !to_irq |=> !if_q)
        else $error("interrupt flag not cleared by vector");

    a_irq_on: assert property (
        if_q && i_global_ie && ie_q |-> o_irq)
        else $error("enabled pending interrupt not requested");

    a_stop_idle: assert property (
        !running |=> cnt_q == '0)
        else $error("stopped watchdog counter not cleared");

    a_irq_mode: assert property (
        to_irq && !chip_rst |=> !o_wdt_reset)
        else $error("interrupt time-out caused a reset");

    a_cnt_hold: assert property (
        running && !i_osc_tick && !i_wdr && !chip_rst |=> $stable(cnt_q))
        else $error("counter moved without an oscillator tick");

    a_restart: assert property (
        i_wdr |=> cnt_q == '0)
        else $error("restart did not clear the counter");

    a_chip_clear: assert property (
        chip_rst |=> cnt_q == '0 && win_q == WIN_IDLE)
        else $error("chip reset did not clear counter or window");

    a_pulse_once: assert property (
        o_wdt_reset |=> !o_wdt_reset)
        else $error("reset pulse longer than one cycle");
endmodule
